// ===== include/arb_timer_pkg.sv
// constants for the serial bus arbiter and bit timer
// assumes an apb slave with 32-bit data, byte addresses
package arb_timer_pkg;
    localparam logic [11:0] ctrl_addr       = 12'h000;
    localparam logic [11:0] count_addr      = 12'h004;
    // control/status bit positions
    localparam int unsigned mode_lo_pos     = 0;
    localparam int unsigned mode_hi_pos     = 1;
    localparam int unsigned clk_sel_pos     = 2;
    localparam int unsigned msb_pos         = 3;
    localparam int unsigned ovfl_pos        = 4;
    localparam int unsigned run_pos         = 5;
    localparam int unsigned done_pos        = 6;
    localparam int unsigned lost_pos        = 7;
    localparam logic [1:0]  mode_idle       = 2'h0;
    localparam logic [1:0]  mode_measure    = 2'h1;
    localparam logic [1:0]  mode_arbitrate  = 2'h2;
    localparam logic [8:0]  sample_bus_div  = 9'h038;
    localparam logic [8:0]  sample_presc    = 9'h008;
    localparam logic [1:0]  div_last        = 2'h3;
    localparam logic [7:0]  ctrl_reset      = 8'h00;
    localparam logic [8:0]  count_reset     = 9'h000;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_run  = 3'b010,
        st_stop = 3'b100
    } arb_state_t;
endpackage

// ===== design/serial_bus_arbiter_bit_timer.sv
// arbiter bit timer: measures bit times and detects lost arbitration
// assumes rx, internal transmit and prescaler tick are synchronous to pclk
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module serial_bus_arbiter_bit_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_pin,
    input  wire logic        internal_transmit_signal,
    input  wire logic        prescaler_tick,
    output logic             tx_pin
);
    logic [1:0]  arbiter_mode_select_reg;
    logic [1:0]  arbiter_mode_select_next;
    logic        clk_sel_reg;
    logic        clk_sel_next;
    logic        measure_done_flag_reg;
    logic        measure_done_flag_next;
    logic        counter_overflow_flag_reg;
    logic        counter_overflow_flag_next;
    logic        arbitration_lost_flag_reg;
    logic        arbitration_lost_flag_next;
    logic [8:0]  count_reg;
    logic [8:0]  count_next;
    logic [1:0]  div_reg;
    logic [1:0]  div_next;
    logic [1:0]  pdiv_reg;
    logic [1:0]  pdiv_next;
    logic        rx_seen_reg;
    logic        rx_seen_next;
    logic        tx_seen_reg;
    logic        tx_seen_next;
    logic        sampled_reg;
    logic        sampled_next;
    logic        tx_pin_next;
    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;
    arb_timer_pkg::arb_state_t state_reg;
    arb_timer_pkg::arb_state_t state_next;

    logic        ctrl_hit;
    logic        count_hit;
    logic        access;
    logic        wr;
    logic        ctrl_wr;
    logic        mapped;
    logic        tick;
    logic        rx_fall;
    logic        rx_rise;
    logic        tx_rise;
    logic [7:0]  ctrl_view;

    assign ctrl_hit  = (paddr == arb_timer_pkg::ctrl_addr);
    assign count_hit = (paddr == arb_timer_pkg::count_addr);
    assign access    = psel & penable & pready;
    assign wr        = access & pwrite;
    assign ctrl_wr   = wr & ctrl_hit;
    assign mapped    = ctrl_hit | count_hit;
    // rx edges are taken from the last seen level at each counter tick, so a
    // glitch between ticks is ignored
    assign rx_fall = tick & rx_seen_reg & ~rx_pin;
    assign rx_rise = tick & ~rx_seen_reg & rx_pin;
    assign tx_rise = ~tx_seen_reg & internal_transmit_signal;
    assign tick    = clk_sel_reg ?
                     (prescaler_tick && pdiv_reg == arb_timer_pkg::div_last)
                   : (div_reg == arb_timer_pkg::div_last);

    always_comb begin
        ctrl_view = arb_timer_pkg::ctrl_reset;
        ctrl_view[arb_timer_pkg::mode_lo_pos] = arbiter_mode_select_reg[0];
        ctrl_view[arb_timer_pkg::mode_hi_pos] = arbiter_mode_select_reg[1];
        ctrl_view[arb_timer_pkg::clk_sel_pos] = clk_sel_reg;
        ctrl_view[arb_timer_pkg::msb_pos]     = count_reg[8];
        ctrl_view[arb_timer_pkg::ovfl_pos]    = counter_overflow_flag_reg;
        ctrl_view[arb_timer_pkg::run_pos]     =
            (state_reg == arb_timer_pkg::st_run);
        ctrl_view[arb_timer_pkg::done_pos]    = measure_done_flag_reg;
        ctrl_view[arb_timer_pkg::lost_pos]    = arbitration_lost_flag_reg;
    end

    // apb slave: one wait state, answers in the second access cycle
    always_comb begin
        pready_next  = psel & penable & ~pready;
        pslverr_next = psel & penable & ~pready & ~mapped;
        prdata_next  = prdata;
        if (psel && penable && !pready && !pwrite) begin
            prdata_next = 32'h0000_0000;
            if (ctrl_hit)
                prdata_next[7:0] = ctrl_view;
            else if (count_hit)
                prdata_next[7:0] = count_reg[7:0];
        end
    end

    // free-running dividers; rx line history is only updated at a tick, transmit history every cycle
    always_comb begin
        div_next     = div_reg + 2'h1;
        pdiv_next    = prescaler_tick ? pdiv_reg + 2'h1 : pdiv_reg;
        rx_seen_next = tick ? rx_pin : rx_seen_reg;
        tx_seen_next = internal_transmit_signal;
    end

    always_comb begin
        arbiter_mode_select_next   = arbiter_mode_select_reg;
        clk_sel_next               = clk_sel_reg;
        measure_done_flag_next     = measure_done_flag_reg;
        counter_overflow_flag_next = counter_overflow_flag_reg;
        arbitration_lost_flag_next = arbitration_lost_flag_reg;
        count_next                 = count_reg;
        state_next                 = state_reg;
        sampled_next               = sampled_reg;

        unique case (arbiter_mode_select_reg)
            arb_timer_pkg::mode_measure: begin
                unique case (state_reg)
                    arb_timer_pkg::st_idle: begin
                        if (clk_sel_reg ? (tick & ~rx_pin)
                                        : rx_fall) begin
                            state_next = arb_timer_pkg::st_run;
                            count_next = arb_timer_pkg::count_reset;
                        end
                    end
                    arb_timer_pkg::st_run: begin
                        if (clk_sel_reg ? rx_rise : rx_fall) begin
                            state_next = arb_timer_pkg::st_stop;
                            measure_done_flag_next = 1'b1;
                        end else if (tick) begin
                            if (count_reg == 9'h1ff) begin
                                counter_overflow_flag_next = 1'b1;
                                state_next = arb_timer_pkg::st_stop;
                            end else begin
                                count_next = count_reg + 9'h001;
                            end
                        end
                    end
                    arb_timer_pkg::st_stop: ;
                    default: state_next = arb_timer_pkg::st_idle;
                endcase
            end
            arb_timer_pkg::mode_arbitrate: begin
                if (tx_rise) begin
                    state_next   = arb_timer_pkg::st_run;
                    count_next   = arb_timer_pkg::count_reset;
                    sampled_next = 1'b0;
                end else if (state_reg == arb_timer_pkg::st_run) begin
                    if (!internal_transmit_signal) begin
                        state_next = arb_timer_pkg::st_idle;
                        count_next = arb_timer_pkg::count_reset;
                    end else if (tick) begin
                        if (!sampled_reg && count_reg == (clk_sel_reg ?
                            arb_timer_pkg::sample_presc :
                            arb_timer_pkg::sample_bus_div)) begin
                            sampled_next = 1'b1;
                            if (!rx_pin)
                                arbitration_lost_flag_next = 1'b1;
                        end
                        if (count_reg == 9'h1ff) begin
                            counter_overflow_flag_next = 1'b1;
                            state_next = arb_timer_pkg::st_stop;
                        end else begin
                            count_next = count_reg + 9'h001;
                        end
                    end
                end
            end
            default: begin
                state_next = arb_timer_pkg::st_idle;
                count_next = arb_timer_pkg::count_reset;
            end
        endcase

        // a write wins over a same-cycle hardware set (for lost only when mode bit 1 is 0): it also restarts
        // the counter, so a flag kept from that cycle would match no count
        if (ctrl_wr) begin
            arbiter_mode_select_next   = pwdata[1:0];
            clk_sel_next               = pwdata[arb_timer_pkg::clk_sel_pos];
            measure_done_flag_next     = 1'b0;
            counter_overflow_flag_next = 1'b0;
            count_next                 = arb_timer_pkg::count_reset;
            state_next                 = arb_timer_pkg::st_idle;
            if (!pwdata[arb_timer_pkg::mode_hi_pos])
                arbitration_lost_flag_next = 1'b0;
        end
    end

    // pin held at 1 while arbitration is lost
    assign tx_pin_next = internal_transmit_signal
                       | arbitration_lost_flag_next;

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_next;
            pready  <= pready_next;
            pslverr <= pslverr_next;
        end
    end

    // line history resets to the idle line level, so no false edge
    // is seen just after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg     <= 2'h0;
            pdiv_reg    <= 2'h0;
            rx_seen_reg <= 1'b1;
            tx_seen_reg <= 1'b1;
        end else begin
            div_reg     <= div_next;
            pdiv_reg    <= pdiv_next;
            rx_seen_reg <= rx_seen_next;
            tx_seen_reg <= tx_seen_next;
        end
    end

    // control fields, flags and the transmit override
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arbiter_mode_select_reg   <= arb_timer_pkg::mode_idle;
            clk_sel_reg               <= 1'b0;
            measure_done_flag_reg     <= 1'b0;
            counter_overflow_flag_reg <= 1'b0;
            arbitration_lost_flag_reg <= 1'b0;
            tx_pin                    <= 1'b1;
        end else begin
            arbiter_mode_select_reg   <= arbiter_mode_select_next;
            clk_sel_reg               <= clk_sel_next;
            measure_done_flag_reg     <= measure_done_flag_next;
            counter_overflow_flag_reg <= counter_overflow_flag_next;
            arbitration_lost_flag_reg <= arbitration_lost_flag_next;
            tx_pin                    <= tx_pin_next;
        end
    end

    // counter and its sequencer; the sample flag restarts with the count
    // so one bit is never sensed twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg   <= arb_timer_pkg::count_reset;
            state_reg   <= arb_timer_pkg::st_idle;
            sampled_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            state_reg   <= state_next;
            sampled_reg <= sampled_next;
        end
    end
endmodule

// ===== tb/arb_timer_monitor.sv
// checker for the arbiter bit timer bus answers and transmit pin
// assumes it is bound to serial_bus_arbiter_bit_timer, one clock
`timescale 1ns/1ps
module arb_timer_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_pin,
    input wire logic        internal_transmit_signal,
    input wire logic        prescaler_tick,
    input wire logic        tx_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr == 12'h000 || paddr == 12'h004;
    a_ready_wait: assert property (psel && !penable ##1 psel && penable
        |-> !pready ##1 pready) else $error("no answer after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_err_data: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h00000000) else $error("refused read not zero");
    a_rdata_held: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("prdata moved outside read");
    a_upper_zero: assert property (pready && !pwrite |->
        prdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_tx_high: assert property ($past(internal_transmit_signal)
        |-> tx_pin) else $error("tx pin low while transmit high");
    c_write: cover property (pready && pwrite && mapped);
    c_read: cover property (pready && !pwrite && mapped);
    c_err: cover property (pready && pslverr);
    c_seized: cover property (tx_pin && !$past(internal_transmit_signal));
endmodule
bind serial_bus_arbiter_bit_timer arb_timer_monitor arb_timer_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .internal_transmit_signal(internal_transmit_signal),
    .prescaler_tick(prescaler_tick), .tx_pin(tx_pin));

// ===== tb/bus_node.sv
// other node on the shared single-wire serial bus
// assumes a wired-and line with pull-up: any node driving 0 wins
`timescale 1ns/1ps
module bus_node (
    input  wire logic tx_pin,
    input  wire logic dominant,
    output logic      rx_pin
);
    // recessive 1 only while no node drives the line low
    assign rx_pin = tx_pin & ~dominant;
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the arbiter bit timer
// assumes package, design, monitor and bus_node compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_top;
    localparam logic [11:0] ca = arb_timer_pkg::ctrl_addr;
    localparam logic [11:0] na = arb_timer_pkg::count_addr;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, itx = 1'b1, dominant = 1'b0, er;
    logic        prescaler_tick = 1'b0, pready, pslverr, rx_pin, tx_pin;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    int          err_count = 0, checks = 0, cycles = 0;
    serial_bus_arbiter_bit_timer serial_bus_arbiter_bit_timer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .internal_transmit_signal(itx), .prescaler_tick(prescaler_tick),
        .tx_pin(tx_pin));
    bus_node bus_node_inst (.tx_pin(tx_pin), .dominant(dominant),
        .rx_pin(rx_pin));
    initial begin
        forever #4 pclk = ~pclk;
    end
    // prescaler output every second cycle, so its quarter is pclk / 8
    always @(posedge pclk) begin
        prescaler_tick <= ~prescaler_tick;
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b0, ca, 8'h00);
        `CHK("ctrl reset", 32'h00000000, rd)
        apb(1'b1, 12'h008, 8'hff);
        `CHK("unmapped", 1'b1, er)
        apb(1'b0, 12'h008, 8'h00);
        `CHK("unmapped read", 32'h00000000, rd)
        `CHK("unmapped read err", 1'b1, er)
        apb(1'b1, ca, 8'hfc);
        apb(1'b0, ca, 8'h00);
        `CHK("ro bits", 32'h00000004, rd)
    endtask
    task automatic t_meas0();
        apb(1'b1, ca, 8'h01);
        dominant <= 1'b1;
        repeat (100) @(posedge pclk);
        apb(1'b0, ca, 8'h00);
        `CHK("running", 2'b10, {rd[5], rd[6]})
        dominant <= 1'b0;
        repeat (100) @(posedge pclk);
        dominant <= 1'b1;
        repeat (20) @(posedge pclk);
        dominant <= 1'b0;
        apb(1'b0, ca, 8'h00);
        `CHK("finished", 2'b01, {rd[5], rd[6]})
        apb(1'b0, na, 8'h00);
        `CHK("bit time", 1'b1, rd[7:0] >= 8'd49 && rd[7:0] <= 8'd53)
    endtask
    task automatic t_meas1();
        dominant <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, ca, 8'h05);
        repeat (156) @(posedge pclk);
        dominant <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(1'b0, na, 8'h00);
        `CHK("break", 1'b1, rd[7:0] >= 8'd18 && rd[7:0] <= 8'd22)
    endtask
    task automatic t_ovfl();
        apb(1'b1, ca, 8'h01);
        dominant <= 1'b1;
        repeat (2100) @(posedge pclk);
        apb(1'b0, ca, 8'h00);
        `CHK("overflow", 3'b101, {rd[4], rd[5], rd[3]})
        apb(1'b0, na, 8'h00);
        `CHK("held max", 32'h000000ff, rd)
        apb(1'b1, ca, 8'h00);
        dominant <= 1'b0;
        repeat (20) @(posedge pclk);
        dominant <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, ca, 8'h00);
        `CHK("cleared", 32'h00000000, rd)
        apb(1'b0, na, 8'h00);
        `CHK("idle count", 32'h00000000, rd)
        apb(1'b1, ca, 8'h03);
        dominant <= 1'b0;
        repeat (20) @(posedge pclk);
        dominant <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, na, 8'h00);
        `CHK("reserved idle", 32'h00000000, rd)
        dominant <= 1'b0;
    endtask
    // hi below the sample point checks that a low transmit restarts
    task automatic t_arb(input logic sel, input logic dom, input int hi,
                         input logic lost);
        itx <= 1'b0;
        apb(1'b1, ca, {5'h00, sel, 2'h2});
        dominant <= dom;
        itx <= 1'b1;
        repeat (hi) @(posedge pclk);
        itx <= 1'b0;
        repeat (300) @(posedge pclk);
        `CHK("tx seized", lost, tx_pin)
        apb(1'b0, ca, 8'h00);
        `CHK("lost", lost, rd[7])
        apb(1'b1, ca, {5'h00, sel, 2'h0});
        apb(1'b0, ca, 8'h00);
        `CHK("lost clear", {5'h00, sel, 2'h0}, rd[7:0])
        `CHK("tx free", 1'b0, tx_pin)
        dominant <= 1'b0;
        itx <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_meas0();
        t_meas1();
        t_ovfl();
        t_arb(1'b0, 1'b1, 300, 1'b1);
        t_arb(1'b1, 1'b1, 300, 1'b1);
        t_arb(1'b0, 1'b0, 300, 1'b0);
        t_arb(1'b0, 1'b1, 100, 1'b0);
        wrap_up();
    end
endmodule
